//--- hw/prte_pkg.sv
// Shared types and constants of the peripheral register transfer executor
`default_nettype none
package prte_pkg;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_SER_DONE = 0;
  localparam int unsigned IRQ_SER_START = 1;
  localparam int unsigned SER_IRQ_EN_POS = 3;
  // Byte addresses of the bus registers
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_WAKEUP = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_MISC = 6'h0c;
  localparam logic [ADDR_W-1:0] ADDR_SHIFT = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 6'h1c;
  // Field positions in the status register
  localparam int unsigned ST_DONE_POS = 0;
  localparam int unsigned ST_RC_POS = 1;
  // Reset values
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [4:0] {
    op_none = 5'h00,
    op_port_cfg_first_write = 5'h01,
    op_port_cfg_second_write = 5'h02,
    op_port_cfg_third_write = 5'h03,
    op_port_cfg_fourth_write = 5'h04,
    op_port_cfg_extra_write = 5'h05,
    op_wakeup_first_write = 5'h06,
    op_wakeup_first_read = 5'h07,
    op_wakeup_second_write = 5'h08,
    op_wakeup_second_read = 5'h09,
    op_wakeup_third_write = 5'h0a,
    op_wakeup_third_read = 5'h0b,
    op_wakeup_fourth_write = 5'h0c,
    op_wakeup_fourth_read = 5'h0d,
    op_pullup_first_write = 5'h0e,
    op_pullup_first_read = 5'h0f,
    op_pullup_second_write = 5'h10,
    op_pullup_second_read = 5'h11,
    op_pullup_third_write = 5'h12,
    op_pullup_third_read = 5'h13,
    serial_data_read_op = 5'h14,
    serial_data_write_op = 5'h15,
    serial_start_op = 5'h16,
    serial_done_skip_op = 5'h17,
    op_serial_ctrl_read = 5'h18,
    op_serial_ctrl_write = 5'h19,
    rc_clock_select_op = 5'h1a,
    osc_ctrl_write_op = 5'h1b,
    clock_mode_read_op = 5'h1c,
    clock_mode_write_op = 5'h1d
  } prte_op_type;

  typedef struct packed {
    logic [NIB_W-1:0] port_drive_cfg_first;
    logic [NIB_W-1:0] port_drive_cfg_second;
    logic [NIB_W-1:0] port_drive_cfg_third;
    logic [NIB_W-1:0] port_drive_cfg_fourth;
    logic [NIB_W-1:0] port_drive_cfg_extra;
    logic [NIB_W-1:0] wakeup_ctrl_first;
    logic [NIB_W-1:0] wakeup_ctrl_second;
    logic [NIB_W-1:0] wakeup_ctrl_third;
    logic [NIB_W-1:0] wakeup_ctrl_fourth;
    logic [NIB_W-1:0] pullup_ctrl_first;
    logic [NIB_W-1:0] pullup_ctrl_second;
    logic [NIB_W-1:0] pullup_ctrl_third;
    logic [NIB_W-1:0] serial_ctrl_reg;
    logic [NIB_W-1:0] clock_mode_reg;
    logic osc_ctrl_bit_reg;
    logic rc_select;
  } prte_cfg_type;

  typedef struct packed {
    logic valid;
    prte_op_type op;
    logic [NIB_W-1:0] acc;
    logic [NIB_W-1:0] b;
  } prte_exec_req_type;

  typedef struct packed {
    logic acc_we;
    logic [NIB_W-1:0] acc;
    logic b_we;
    logic [NIB_W-1:0] b;
    logic skip;
  } prte_exec_rsp_type;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [DATA_W-1:0] writedata;
  } prte_bus_req_type;

  typedef struct packed {
    prte_cfg_type cfg;
    logic [7:0] serial_shift;
    logic serial_done_flag;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    prte_exec_rsp_type rsp;
    logic serial_start;
    logic bus_ack;
    logic [DATA_W-1:0] readdata;
  } prte_state_type;
endpackage
`default_nettype wire

//--- hw/prte_exec.sv
// Peripheral register transfer executor with Avalon-MM register slave
//
// The register offsets and register access over Avalon-MM were decided locally.
`default_nettype none
module prte_exec
  import prte_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire prte_exec_req_type exec_req,
  input wire logic [NIB_W-1:0] irq_ctrl_second,
  input wire logic serial_done_in,
  input wire logic [7:0] serial_rx_data,
  output prte_exec_rsp_type exec_rsp,
  output prte_cfg_type cfg,
  output logic [7:0] serial_shift,
  output logic serial_start,
  output logic irq,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest
);
  prte_state_type s_q;
  prte_state_type s_d;
  prte_bus_req_type bus;
  logic serial_irq_enable_bit;

  function automatic logic [DATA_W-1:0] pad_word(input logic [23:0] v);
    pad_word = {8'h00, v};
  endfunction

  assign bus = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  assign serial_irq_enable_bit = irq_ctrl_second[SER_IRQ_EN_POS];

  always_comb begin
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic done_clr;
    logic bus_take;
    irq_set = IRQ_RST;
    irq_clr = IRQ_RST;
    done_clr = 1'b0;
    bus_take = (bus.read || bus.write) && !s_q.bus_ack;
    s_d = s_q;
    // Results are pulses; registered so data outputs come from flops
    s_d.rsp.acc_we = 1'b0;
    s_d.rsp.b_we = 1'b0;
    s_d.rsp.skip = 1'b0;
    s_d.serial_start = 1'b0;
    // Carry is never driven here; only the done test can skip
    if (exec_req.valid) begin
      case (exec_req.op)
        op_port_cfg_first_write: begin
          s_d.cfg.port_drive_cfg_first = exec_req.acc;
        end
        op_port_cfg_second_write: begin
          s_d.cfg.port_drive_cfg_second = exec_req.acc;
        end
        op_port_cfg_third_write: begin
          s_d.cfg.port_drive_cfg_third = exec_req.acc;
        end
        op_port_cfg_fourth_write: begin
          s_d.cfg.port_drive_cfg_fourth = exec_req.acc;
        end
        op_port_cfg_extra_write: begin
          s_d.cfg.port_drive_cfg_extra = exec_req.acc;
        end
        op_wakeup_first_write: begin
          s_d.cfg.wakeup_ctrl_first = exec_req.acc;
        end
        op_wakeup_second_write: begin
          s_d.cfg.wakeup_ctrl_second = exec_req.acc;
        end
        op_wakeup_third_write: begin
          s_d.cfg.wakeup_ctrl_third = exec_req.acc;
        end
        op_wakeup_fourth_write: begin
          s_d.cfg.wakeup_ctrl_fourth = exec_req.acc;
        end
        op_wakeup_first_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.wakeup_ctrl_first;
        end
        op_wakeup_second_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.wakeup_ctrl_second;
        end
        op_wakeup_third_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.wakeup_ctrl_third;
        end
        op_wakeup_fourth_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.wakeup_ctrl_fourth;
        end
        op_pullup_first_write: begin
          s_d.cfg.pullup_ctrl_first = exec_req.acc;
        end
        op_pullup_second_write: begin
          s_d.cfg.pullup_ctrl_second = exec_req.acc;
        end
        op_pullup_third_write: begin
          s_d.cfg.pullup_ctrl_third = exec_req.acc;
        end
        op_pullup_first_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.pullup_ctrl_first;
        end
        op_pullup_second_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.pullup_ctrl_second;
        end
        op_pullup_third_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.pullup_ctrl_third;
        end
        serial_data_read_op: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.b_we = 1'b1;
          s_d.rsp.b = s_q.serial_shift[7:4];
          s_d.rsp.acc = s_q.serial_shift[3:0];
        end
        serial_data_write_op: begin
          s_d.serial_shift = {exec_req.b, exec_req.acc};
        end
        serial_start_op: begin
          done_clr = 1'b1;
          s_d.serial_start = 1'b1;
          irq_set[IRQ_SER_START] = 1'b1;
        end
        serial_done_skip_op: begin
          // With the interrupt path enabled the test does nothing
          if (!serial_irq_enable_bit) begin
            done_clr = 1'b1;
            s_d.rsp.skip = s_q.serial_done_flag;
          end
        end
        op_serial_ctrl_read: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.serial_ctrl_reg;
        end
        op_serial_ctrl_write: begin
          s_d.cfg.serial_ctrl_reg = exec_req.acc;
        end
        rc_clock_select_op: begin
          s_d.cfg.rc_select = 1'b1;
        end
        osc_ctrl_write_op: begin
          s_d.cfg.osc_ctrl_bit_reg = exec_req.acc[0];
        end
        clock_mode_read_op: begin
          s_d.rsp.acc_we = 1'b1;
          s_d.rsp.acc = s_q.cfg.clock_mode_reg;
        end
        clock_mode_write_op: begin
          s_d.cfg.clock_mode_reg = exec_req.acc;
        end
        default: begin
          s_d.rsp.skip = 1'b0;
        end
      endcase
    end
    // A completion arriving with a clear still sets the flag
    if (serial_done_in) begin
      irq_set[IRQ_SER_DONE] = 1'b1;
      if (!(exec_req.valid && exec_req.op == serial_data_write_op)) begin
        s_d.serial_shift = serial_rx_data;
      end
    end
    s_d.serial_done_flag = (s_q.serial_done_flag && !done_clr) || serial_done_in;
    // Bus: one wait cycle, answer on the second cycle of each request
    s_d.bus_ack = bus_take;
    if (bus_take && bus.read) begin
      if (bus.address == ADDR_STATUS) begin
        s_d.readdata = WORD_ZERO;
        s_d.readdata[ST_DONE_POS] = s_q.serial_done_flag;
        s_d.readdata[ST_RC_POS] = s_q.cfg.rc_select;
      end else if (bus.address == ADDR_PORT_CFG) begin
        s_d.readdata = pad_word({4'h0, s_q.cfg.port_drive_cfg_extra,
          s_q.cfg.port_drive_cfg_fourth, s_q.cfg.port_drive_cfg_third,
          s_q.cfg.port_drive_cfg_second, s_q.cfg.port_drive_cfg_first});
      end else if (bus.address == ADDR_WAKEUP) begin
        s_d.readdata = pad_word({8'h00, s_q.cfg.wakeup_ctrl_fourth,
          s_q.cfg.wakeup_ctrl_third, s_q.cfg.wakeup_ctrl_second,
          s_q.cfg.wakeup_ctrl_first});
      end else if (bus.address == ADDR_MISC) begin
        s_d.readdata = pad_word({3'h0, s_q.cfg.osc_ctrl_bit_reg,
          s_q.cfg.clock_mode_reg, s_q.cfg.serial_ctrl_reg,
          s_q.cfg.pullup_ctrl_third, s_q.cfg.pullup_ctrl_second,
          s_q.cfg.pullup_ctrl_first});
      end else if (bus.address == ADDR_SHIFT) begin
        s_d.readdata = pad_word({16'h0000, s_q.serial_shift});
      end else if (bus.address == ADDR_IRQ_STATUS) begin
        s_d.readdata = {30'h0000_0000, s_q.irq_status};
      end else if (bus.address == ADDR_IRQ_ENABLE) begin
        s_d.readdata = {30'h0000_0000, s_q.irq_enable};
      end else begin
        // Unmapped and write-only addresses read as zero
        s_d.readdata = WORD_ZERO;
      end
    end
    // Writes take effect on the accepting edge, like the master expects
    if (s_q.bus_ack && bus.write) begin
      if (bus.address == ADDR_IRQ_ENABLE) begin
        s_d.irq_enable = bus.writedata[IRQ_W-1:0];
      end else if (bus.address == ADDR_IRQ_CLEAR) begin
        irq_clr = bus.writedata[IRQ_W-1:0];
      end
    end
    s_d.irq_status = (s_q.irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign exec_rsp = s_q.rsp;
  assign cfg = s_q.cfg;
  assign serial_shift = s_q.serial_shift;
  assign serial_start = s_q.serial_start;
  assign irq = |(s_q.irq_status & s_q.irq_enable);
  assign avs_readdata = s_q.readdata;
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.bus_ack;
endmodule
`default_nettype wire

//--- bench/prte_exec_checker.sv
// Concurrent checks on the transfer executor ports
`default_nettype none
module prte_exec_checker
  import prte_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire prte_exec_req_type exec_req,
  input wire logic [NIB_W-1:0] irq_ctrl_second,
  input wire prte_exec_rsp_type exec_rsp,
  input wire prte_cfg_type cfg,
  input wire logic [7:0] serial_shift,
  input wire logic serial_start,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  prte_op_type op_v;
  assign op_v = exec_req.valid ? exec_req.op : op_none;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cfg_first: assert property (op_v == op_port_cfg_first_write
    |=> cfg.port_drive_cfg_first == $past(exec_req.acc)) else $error("first cfg not loaded");
  a_cfg_extra: assert property (op_v == op_port_cfg_extra_write
    |=> cfg.port_drive_cfg_extra == $past(exec_req.acc)) else $error("extra cfg not loaded");
  a_wake_read: assert property (op_v == op_wakeup_first_read
    |=> exec_rsp.acc_we && exec_rsp.acc == $past(cfg.wakeup_ctrl_first))
    else $error("wakeup read wrong");
  a_ser_read: assert property (op_v == serial_data_read_op |=> exec_rsp.b_we
    && exec_rsp.b == $past(serial_shift[7:4]) && exec_rsp.acc == $past(serial_shift[3:0]))
    else $error("serial read wrong");
  a_ser_write: assert property (op_v == serial_data_write_op
    |=> serial_shift == {$past(exec_req.b), $past(exec_req.acc)}) else $error("shift not loaded");
  a_start_pulse: assert property (serial_start == ($past(op_v) == serial_start_op))
    else $error("start pulse mismatch");
  a_skip_cause: assert property (exec_rsp.skip
    |-> $past(op_v) == serial_done_skip_op && !$past(irq_ctrl_second[SER_IRQ_EN_POS]))
    else $error("unexpected skip");
  a_osc_bit: assert property (op_v == osc_ctrl_write_op
    |=> cfg.osc_ctrl_bit_reg == $past(exec_req.acc[0])) else $error("osc bit wrong");
  a_rc_sel: assert property (op_v == rc_clock_select_op |=> cfg.rc_select [*2])
    else $error("rc select not set");
  a_mode_read: assert property (op_v == clock_mode_read_op
    |=> exec_rsp.acc_we && exec_rsp.acc == $past(cfg.clock_mode_reg)) else $error("mode read");
  a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait cycle too long");
endmodule
bind prte_exec prte_exec_checker i_prte_exec_checker (.clk(clk), .rst_n(rst_n),
  .exec_req(exec_req), .irq_ctrl_second(irq_ctrl_second), .exec_rsp(exec_rsp), .cfg(cfg),
  .serial_shift(serial_shift), .serial_start(serial_start), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

//--- bench/test_prte_exec.sv
// Directed bench for the transfer executor
`default_nettype none
module test_prte_exec
  import prte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, done_in, rd, wr, st, irq, wait_rq;
  prte_exec_req_type req;
  prte_exec_rsp_type rsp, r;
  prte_cfg_type cfg;
  logic [3:0] ictl;
  logic [7:0] rx, shift;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, d;
  int errors, tests_run;
  prte_exec i_prte_exec (.clk(clk), .rst_n(rst_n), .exec_req(req), .irq_ctrl_second(ictl),
    .serial_done_in(done_in), .serial_rx_data(rx), .exec_rsp(rsp), .cfg(cfg),
    .serial_shift(shift), .serial_start(st), .irq(irq), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_rq));
  task automatic complete_run;
    $display("Comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= v;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    // Read data is taken at the accepting edge itself
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_rq !== 1'b0) chk(32'h1, 32'h0);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(d, exp);
  endtask
  task automatic ex(input prte_op_type op, input logic [3:0] a, input logic [3:0] b,
                    input logic sk);
    @(posedge clk);
    req <= {1'b1, op, a, b};
    @(posedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
    r = rsp;
    chk(r.skip, sk);
  endtask
  task automatic done_pulse(input logic [7:0] v);
    @(posedge clk);
    rx <= v;
    done_in <= 1'b1;
    @(posedge clk);
    done_in <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    ictl = 4'h0;
    done_in = 1'b0;
    rx = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    errors = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Last address of the sweep is unmapped
    for (int i = 0; i < 9; i++) rdc(6'(4 * i), 32'h0);
    bus(1'b1, ADDR_PORT_CFG, 32'hffff_ffff);
    rdc(ADDR_PORT_CFG, 32'h0);
    for (int i = 0; i < 5; i++) ex(prte_op_type'(i + 1), 4'(i + 1), 4'h0, 1'b0);
    rdc(ADDR_PORT_CFG, 32'h0005_4321);
    for (int i = 0; i < 4; i++) ex(prte_op_type'(6 + 2 * i), 4'(10 + i), 4'h0, 1'b0);
    rdc(ADDR_WAKEUP, 32'h0000_dcba);
    for (int i = 0; i < 4; i++) begin
      ex(prte_op_type'(7 + 2 * i), 4'h0, 4'h0, 1'b0);
      chk({r.acc_we, r.acc}, {1'b1, 4'(10 + i)});
    end
    for (int i = 0; i < 3; i++) ex(prte_op_type'(14 + 2 * i), 4'(7 + i), 4'h0, 1'b0);
    ex(op_serial_ctrl_write, 4'he, 4'h0, 1'b0);
    ex(clock_mode_write_op, 4'h6, 4'h0, 1'b0);
    ex(osc_ctrl_write_op, 4'hb, 4'h0, 1'b0);
    rdc(ADDR_MISC, 32'h0016_e987);
    for (int i = 0; i < 3; i++) begin
      ex(prte_op_type'(15 + 2 * i), 4'h0, 4'h0, 1'b0);
      chk({r.acc_we, r.acc}, {1'b1, 4'(7 + i)});
    end
    ex(op_serial_ctrl_read, 4'h0, 4'h0, 1'b0);
    chk({r.acc_we, r.acc}, 5'h1e);
    ex(clock_mode_read_op, 4'h0, 4'h0, 1'b0);
    chk({r.acc_we, r.acc}, 5'h16);
    ex(osc_ctrl_write_op, 4'ha, 4'h0, 1'b0);
    rdc(ADDR_MISC, 32'h0006_e987);
    ex(rc_clock_select_op, 4'h0, 4'h0, 1'b0);
    rdc(ADDR_STATUS, 32'h2);
    chk(cfg.rc_select, 1'b1);
    ex(serial_data_write_op, 4'h5, 4'ha, 1'b0);
    rdc(ADDR_SHIFT, 32'ha5);
    chk(shift, 8'ha5);
    ex(serial_data_read_op, 4'h0, 4'h0, 1'b0);
    chk({r.b_we, r.b, r.acc_we, r.acc}, 10'h355);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
    done_pulse(8'h3c);
    rdc(ADDR_SHIFT, 32'h3c);
    rdc(ADDR_STATUS, 32'h3);
    chk(irq, 1'b1);
    ictl <= 4'h8;
    ex(serial_done_skip_op, 4'h0, 4'h0, 1'b0);
    rdc(ADDR_STATUS, 32'h3);
    ictl <= 4'h7;
    ex(serial_done_skip_op, 4'h0, 4'h0, 1'b1);
    rdc(ADDR_STATUS, 32'h2);
    ex(serial_done_skip_op, 4'h0, 4'h0, 1'b0);
    done_pulse(8'h81);
    ex(serial_start_op, 4'h0, 4'h0, 1'b0);
    chk(st, 1'b1);
    rdc(ADDR_STATUS, 32'h2);
    rdc(ADDR_IRQ_STATUS, 32'h3);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h0);
    rdc(ADDR_IRQ_ENABLE, 32'h0);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h3);
    rdc(ADDR_IRQ_ENABLE, 32'h3);
    chk(irq, 1'b1);
    bus(1'b1, ADDR_IRQ_CLEAR, 32'h3);
    rdc(ADDR_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
